// ### scc_pkg.sv
/*
  constants, register map and types for the sync input and coast control
  block; assumes a 20 MHz core clock and classic wishbone with 32-bit data
*/
`default_nettype none
package scc_pkg;
  // core clock
  localparam int CORE_CLK_PERIOD_NS = 50;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_HSYNC_CFG = 6'h12;
  localparam logic [5:0] IDX_COAST_CFG = 6'h18;
  localparam logic [5:0] IDX_SOG_THR = 6'h20;
  localparam logic [5:0] IDX_CTRL = 6'h21;
  localparam logic [5:0] IDX_HS_WIDTH = 6'h22;
  localparam logic [5:0] IDX_LINE_TARGET = 6'h23;
  localparam logic [5:0] IDX_STATUS = 6'h24;

  // field positions
  localparam int HS_POL_LSB = 4;
  localparam int COAST_POL_LSB = 5;
  localparam int CTRL_CH_SEL = 0;
  localparam int CTRL_USE_SOG = 1;
  localparam int CTRL_EXT_CLK = 2;
  localparam int CTRL_OUT_POL = 3;
  localparam int ST_COAST = 0;
  localparam int ST_EXT = 1;
  localparam int ST_COUNT_LSB = 4;
  localparam int ST_DIV_LSB = 16;

  // widths fixed by the register layout
  localparam int GREEN_W = 10;
  localparam int LINE_W = 12;
  localparam int DIV_W = 16;

  // values after reset
  localparam logic [1:0] HS_POL_RST = 2'h0;
  localparam logic [1:0] COAST_POL_RST = 2'h1;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] HS_WIDTH_RST = 8'h20;
  localparam logic [11:0] LINE_TARGET_RST = 12'h320;
  localparam logic [15:0] DIV_RST = 16'h0001;

  // slicing threshold in millivolts
  localparam int THR_STEP_MV = 10;
  localparam int THR_MIN_MV = 10;
  localparam int THR_MAX_MV = 330;
  localparam int THR_RESET_MV = 150;
  localparam logic [5:0] THR_MIN_STEPS = 6'(THR_MIN_MV / THR_STEP_MV);
  localparam logic [5:0] THR_MAX_STEPS = 6'(THR_MAX_MV / THR_STEP_MV);
  localparam logic [5:0] THR_RESET_STEPS = 6'(THR_RESET_MV / THR_STEP_MV);

  // times, least times rounded up
  localparam int PEAK_DECAY_NS = 1000;
  localparam int PEAK_DECAY_CYCLES = (PEAK_DECAY_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int VSEP_TIME_NS = 10000;
  localparam int VSEP_CYCLES = (VSEP_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // rebuilt sync pulse states
  typedef enum logic [1:0] {
    RB_IDLE = 2'b00,
    RB_ARMED = 2'b01,
    RB_PULSE = 2'b10
  } scc_rb_state_t;
endpackage
`default_nettype wire

// ### scc_sync_sep.sv
/*
  splits a composite sync (sync tips low) into a horizontal part and a
  vertical flag by pulse length; input is synchronous to the core clock
*/
`timescale 1ns/1ps
`default_nettype none
module scc_sync_sep #(
  parameter int VSEP_CYCLES = scc_pkg::VSEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // composite in
  input wire logic comp_sync,
  // separated out
  output logic h_sync,
  output logic v_flag
);
  localparam int CW = $clog2(VSEP_CYCLES + 1);
  localparam logic [CW-1:0] RUN_MAX = CW'(VSEP_CYCLES);

  logic last;
  logic [CW-1:0] run;

  wire same = comp_sync == last;
  wire long_run = run == RUN_MAX;
  wire [CW-1:0] next_run = !same ? '0 : (long_run ? run : run + CW'(1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last <= 1'b1;
      run <= '0;
      v_flag <= 1'b0;
      h_sync <= 1'b1;
    end else begin
      last <= comp_sync;
      run <= next_run;
      // long low is vertical, long high ends it
      if (long_run) begin
        v_flag <= ~last;
      end
      // horizontal part held inactive in the vertical interval
      h_sync <= v_flag | comp_sync; // RQ8
    end
  end
endmodule
`default_nettype wire

// ### scc_hs_rebuild.sv
/*
  rebuilds a horizontal sync pulse aligned to the pixel strobe, width in
  pixel periods; lead and pix_en are one-cycle pulses of the core clock
*/
`timescale 1ns/1ps
`default_nettype none
module scc_hs_rebuild (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timing in
  input wire logic lead,
  input wire logic pix_en,
  input wire logic [7:0] width,
  // pulse out
  output logic active
);
  scc_pkg::scc_rb_state_t state;
  scc_pkg::scc_rb_state_t next_state;
  logic [7:0] cnt;

  wire done = cnt >= width;

  always_comb begin
    next_state = state;
    case (state)
      scc_pkg::RB_IDLE: begin
        if (lead) next_state = scc_pkg::RB_ARMED;
      end
      scc_pkg::RB_ARMED: begin
        if (pix_en) next_state = scc_pkg::RB_PULSE;
      end
      scc_pkg::RB_PULSE: begin
        if (lead) next_state = scc_pkg::RB_ARMED;
        else if (pix_en && done) next_state = scc_pkg::RB_IDLE;
      end
      default: next_state = scc_pkg::RB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= scc_pkg::RB_IDLE;
      cnt <= 8'h00;
      active <= 1'b0;
    end else begin
      state <= next_state;
      // pulse starts on the first pixel after the lead edge
      if (state == scc_pkg::RB_ARMED && pix_en) cnt <= 8'h01; // RQ15
      else if (state == scc_pkg::RB_PULSE && pix_en && !done) cnt <= cnt + 8'h01;
      active <= next_state == scc_pkg::RB_PULSE;
    end
  end
endmodule
`default_nettype wire

// ### scc_top.sv
/*
  sync input and coast control: channel select, hsync leading edge with
  sense programmable on the hsync pins, sync-on-green slicer and separator,
  strobe generator with coast and external clock, rebuilt hsync output.
  assumes all sync pins synchronous to CORE_CLK and a classic wishbone
  master with 32-bit data; green inputs are levels in millivolts.
*/
// Notes on behaviour
// RQ1: selected hsync is line and frequency reference
// RQ2: hsync sense from index 0x12 bits 5:4
// RQ3: only the leading edge is ever used
// RQ4: setting 0 falling edge, 1 rising edge; with sync on green selected the falling edge is always used
// RQ5: slice threshold 10 to 330 mV, 10 mV steps
// RQ6: threshold is 150 mV after reset
// RQ7: sliced output is noninverted comparator result
// RQ8: composite sync separated before horizontal use
// RQ9: coast freezes generator frequency and phase
// RQ10: coast sense from index 0x18 bits 6:5
// RQ11: coast sense is 1 after reset
// RQ12: board keeps unused coast inactive
// RQ13: external clock may replace generated pixel clock
// RQ14: coast and external clock stay independent
// RQ15: rebuilt hsync aligned, programmable polarity, width
// RQ16: one of two channels selected by setting
`timescale 1ns/1ps
`default_nettype none
module scc_top #(
  parameter int VSEP_CYCLES = scc_pkg::VSEP_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // sync inputs, two channels
  input wire logic HSYNC_IN_CH0,
  input wire logic HSYNC_IN_CH1,
  input wire logic VSYNC_IN_CH0,
  input wire logic VSYNC_IN_CH1,
  input wire logic [9:0] GREEN_SYNC_IN_CH0,
  input wire logic [9:0] GREEN_SYNC_IN_CH1,
  // clock generator controls
  input wire logic COAST_IN,
  input wire logic EXTERNAL_PIXEL_CLOCK,
  // outputs
  output logic SLICED_SYNC_OUT,
  output logic HSYNC_REBUILT_OUT,
  output logic VSYNC_OUT,
  output logic PIXEL_CLOCK_OUT
);
  localparam int DECAY_W = $clog2(scc_pkg::PEAK_DECAY_CYCLES);
  localparam logic [DECAY_W-1:0] DECAY_LAST = DECAY_W'(scc_pkg::PEAK_DECAY_CYCLES - 1);
  localparam logic [9:0] PEAK_TOP = 10'h3ff;
  localparam logic [11:0] LINE_TOP = 12'hfff;
  localparam logic [15:0] DIV_TOP = 16'hffff;

  function automatic logic [31:0] wb_merge(
    input logic [31:0] old,
    input logic [31:0] din,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[i*8 +: 8] = din[i*8 +: 8];
    end
    return res;
  endfunction

  // registers
  logic [1:0] hs_pol;
  logic [1:0] coast_pol;
  logic [5:0] thr_steps;
  logic [3:0] ctrl;
  logic [7:0] hs_width;
  logic [11:0] line_target;

  // internal state
  logic [9:0] neg_peak;
  logic [DECAY_W-1:0] decay_cnt;
  logic hs_prev;
  logic ext_prev;
  logic [15:0] div;
  logic [15:0] div_cnt;
  logic [11:0] pix_cnt;
  logic [11:0] last_cnt;
  logic h_sep;
  logic v_sep;
  logic rb_active;

  // bus decode
  wire [5:0] wb_idx = WB_ADR_I[7:2];
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I;
  wire hit_hs = wb_idx == scc_pkg::IDX_HSYNC_CFG;
  wire hit_coast = wb_idx == scc_pkg::IDX_COAST_CFG;
  wire hit_thr = wb_idx == scc_pkg::IDX_SOG_THR;
  wire hit_ctrl = wb_idx == scc_pkg::IDX_CTRL;
  wire hit_width = wb_idx == scc_pkg::IDX_HS_WIDTH;
  wire hit_target = wb_idx == scc_pkg::IDX_LINE_TARGET;
  wire hit_status = wb_idx == scc_pkg::IDX_STATUS;

  // register images as read
  wire [31:0] img_hs = {26'h0, hs_pol, 4'h0};
  wire [31:0] img_coast = {25'h0, coast_pol, 5'h0};
  wire [31:0] img_thr = {26'h0, thr_steps};
  wire [31:0] img_ctrl = {28'h0, ctrl};
  wire [31:0] img_width = {24'h0, hs_width};
  wire [31:0] img_target = {20'h0, line_target};
  wire coast_act;
  wire ext_sel;
  wire [31:0] img_status = {div, last_cnt, 2'h0, ext_sel, coast_act};

  // merged write data
  wire [31:0] wr_hs = wb_merge(img_hs, WB_DAT_I, WB_SEL_I);
  wire [31:0] wr_coast = wb_merge(img_coast, WB_DAT_I, WB_SEL_I);
  wire [31:0] wr_thr = wb_merge(img_thr, WB_DAT_I, WB_SEL_I);
  wire [31:0] wr_ctrl = wb_merge(img_ctrl, WB_DAT_I, WB_SEL_I);
  wire [31:0] wr_width = wb_merge(img_width, WB_DAT_I, WB_SEL_I);
  wire [31:0] wr_target = wb_merge(img_target, WB_DAT_I, WB_SEL_I);

  // threshold writes clamped into the legal step range
  wire [7:0] thr_raw = wr_thr[7:0];
  wire thr_low = thr_raw < {2'h0, scc_pkg::THR_MIN_STEPS};
  wire thr_high = thr_raw > {2'h0, scc_pkg::THR_MAX_STEPS};
  wire [5:0] next_thr = thr_low ? scc_pkg::THR_MIN_STEPS :
                        thr_high ? scc_pkg::THR_MAX_STEPS : thr_raw[5:0]; // RQ5

  // read mux, unmapped reads as zero
  wire [31:0] next_rdata = hit_hs ? img_hs :
                           hit_coast ? img_coast :
                           hit_thr ? img_thr :
                           hit_ctrl ? img_ctrl :
                           hit_width ? img_width :
                           hit_target ? img_target :
                           hit_status ? img_status : 32'h0;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req) WB_DAT_O <= next_rdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hs_pol <= scc_pkg::HS_POL_RST;
      coast_pol <= scc_pkg::COAST_POL_RST; // RQ11
      thr_steps <= scc_pkg::THR_RESET_STEPS; // RQ6
      ctrl <= scc_pkg::CTRL_RST;
      hs_width <= scc_pkg::HS_WIDTH_RST;
      line_target <= scc_pkg::LINE_TARGET_RST;
    end else if (wb_wr) begin
      if (hit_hs) hs_pol <= wr_hs[scc_pkg::HS_POL_LSB +: 2]; // RQ2
      if (hit_coast) coast_pol <= wr_coast[scc_pkg::COAST_POL_LSB +: 2]; // RQ10
      if (hit_thr) thr_steps <= next_thr;
      if (hit_ctrl) ctrl <= wr_ctrl[3:0];
      if (hit_width) hs_width <= wr_width[7:0];
      if (hit_target) line_target <= wr_target[11:0];
    end
  end

  // channel selection
  wire ch_sel = ctrl[scc_pkg::CTRL_CH_SEL];
  wire use_sog = ctrl[scc_pkg::CTRL_USE_SOG];
  assign ext_sel = ctrl[scc_pkg::CTRL_EXT_CLK];
  wire out_pol = ctrl[scc_pkg::CTRL_OUT_POL];
  wire hs_pin = ch_sel ? HSYNC_IN_CH1 : HSYNC_IN_CH0; // RQ16
  wire vs_pin = ch_sel ? VSYNC_IN_CH1 : VSYNC_IN_CH0; // RQ16
  wire [9:0] green = ch_sel ? GREEN_SYNC_IN_CH1 : GREEN_SYNC_IN_CH0; // RQ16

  // slicer against a tracked negative peak
  wire decay_tick = decay_cnt == DECAY_LAST;
  wire [10:0] thr_mv = 11'(thr_steps * scc_pkg::THR_STEP_MV); // RQ5
  wire [10:0] slice_level = {1'b0, neg_peak} + thr_mv;
  wire slice_hit = {1'b0, green} > slice_level;
  wire peak_drop = green < neg_peak;
  wire peak_rise = decay_tick & (neg_peak != PEAK_TOP);

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      decay_cnt <= '0;
      neg_peak <= PEAK_TOP;
      SLICED_SYNC_OUT <= 1'b1;
    end else begin
      decay_cnt <= decay_tick ? '0 : decay_cnt + DECAY_W'(1);
      if (peak_drop) neg_peak <= green;
      else if (peak_rise) neg_peak <= neg_peak + 10'h001;
      SLICED_SYNC_OUT <= slice_hit; // RQ7
    end
  end

  scc_sync_sep #(
    .VSEP_CYCLES(VSEP_CYCLES)
  ) u_sep (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .comp_sync(SLICED_SYNC_OUT),
    .h_sync(h_sep),
    .v_flag(v_sep)
  );

  // leading edge of the selected horizontal reference
  wire hs_src = use_sog ? h_sep : hs_pin; // RQ8
  wire lead_rise = hs_pol[0] & ~use_sog; // RQ4
  wire hs_lead = lead_rise ? (hs_src & ~hs_prev) : (~hs_src & hs_prev); // RQ3

  // coast sense, independent of the clock source
  assign coast_act = coast_pol[0] ? COAST_IN : ~COAST_IN; // RQ10
  wire track = hs_lead & ~coast_act; // RQ9

  // generated pixel strobe, frequency and phase follow hsync
  wire int_tick = div_cnt >= (div - 16'h0001);
  wire too_many = pix_cnt > line_target;
  wire too_few = pix_cnt < line_target;
  wire div_up = too_many & (div != DIV_TOP);
  wire div_dn = too_few & (div > 16'h0001);
  wire ext_tick = EXTERNAL_PIXEL_CLOCK & ~ext_prev;
  wire pix_en = ext_sel ? ext_tick : int_tick; // RQ13

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hs_prev <= 1'b1;
      ext_prev <= 1'b0;
    end else begin
      hs_prev <= hs_src;
      ext_prev <= EXTERNAL_PIXEL_CLOCK;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt <= 16'h0000;
    end else if (track || int_tick) begin
      div_cnt <= 16'h0000; // RQ1
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div <= scc_pkg::DIV_RST;
      pix_cnt <= 12'h000;
      last_cnt <= 12'h000;
    end else if (track) begin
      // one correction step per line, held while coasting
      if (div_up) div <= div + 16'h0001; // RQ1
      else if (div_dn) div <= div - 16'h0001; // RQ1
      pix_cnt <= 12'h000;
      last_cnt <= pix_cnt;
    end else if (int_tick && pix_cnt != LINE_TOP) begin
      pix_cnt <= pix_cnt + 12'h001;
    end
  end

  scc_hs_rebuild u_rebuild (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .lead(hs_lead),
    .pix_en(pix_en),
    .width(hs_width),
    .active(rb_active)
  );

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIXEL_CLOCK_OUT <= 1'b0;
      HSYNC_REBUILT_OUT <= 1'b0;
      VSYNC_OUT <= 1'b0;
    end else begin
      // external strobe passes whatever coast does
      PIXEL_CLOCK_OUT <= pix_en; // RQ14
      HSYNC_REBUILT_OUT <= rb_active ^ ~out_pol; // RQ15
      VSYNC_OUT <= use_sog ? v_sep : vs_pin;
    end
  end
endmodule
`default_nettype wire

// ### scc_checker.sv
/*
  port-level checks of the sync input and coast control block.
  bound into scc_top; snoops wishbone writes to follow the control bits.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_checker #(
  parameter int VSEP_CYCLES = 200
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // sync pins
  input wire logic VSYNC_IN_CH0,
  input wire logic VSYNC_IN_CH1,
  input wire logic [9:0] GREEN_SYNC_IN_CH0,
  input wire logic [9:0] GREEN_SYNC_IN_CH1,
  input wire logic EXTERNAL_PIXEL_CLOCK,
  // outputs
  input wire logic SLICED_SYNC_OUT,
  input wire logic VSYNC_OUT,
  input wire logic PIXEL_CLOCK_OUT
);
  logic [3:0] ctl;
  logic [8:0] lo_cnt;
  wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire logic ctl_wr = take && WB_WE_I && WB_ADR_I == 8'h84 && WB_SEL_I[0];
  wire logic green_low = GREEN_SYNC_IN_CH0 == 10'h0 && GREEN_SYNC_IN_CH1 == 10'h0;
  wire logic vsel = ctl[0] ? VSYNC_IN_CH1 : VSYNC_IN_CH0;
  // control bits, updated on the taking edge like the design
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) ctl <= 4'h0;
    else if (ctl_wr) ctl <= WB_DAT_I[3:0];
  end
  // run of zero green while sliced sync feeds vertical
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) lo_cnt <= 9'h0;
    else if (!(ctl[1] && green_low)) lo_cnt <= 9'h0;
    else if (lo_cnt != 9'h1ff) lo_cnt <= lo_cnt + 9'h1;
  end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  property p_ack_next;
    take |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_one;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_idle;
    !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
  property p_dat_hold;
    !take |=> $stable(WB_DAT_O);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_slice_low;
    green_low [*2] |=> !SLICED_SYNC_OUT;
  endproperty
  a_slice_low: assert property (p_slice_low) else $error("sliced high at peak");
  property p_vs_follow;
    !ctl[1] |=> VSYNC_OUT == $past(vsel);
  endproperty
  a_vs_follow: assert property (p_vs_follow) else $error("vsync not selected pin");
  property p_vs_sep;
    lo_cnt == 9'(VSEP_CYCLES + 6) |-> VSYNC_OUT;
  endproperty
  a_vs_sep: assert property (p_vs_sep) else $error("vertical not separated");
  property p_ext_pix;
    ctl[2] && $rose(EXTERNAL_PIXEL_CLOCK) |-> ##[1:3] PIXEL_CLOCK_OUT;
  endproperty
  a_ext_pix: assert property (p_ext_pix) else $error("no pixel from ext clock");
  c_write: cover property (ctl_wr);
  c_ext: cover property (ctl[2] && PIXEL_CLOCK_OUT);
  c_vsep: cover property (ctl[1] && VSYNC_OUT);
endmodule
bind scc_top scc_checker #(.VSEP_CYCLES(VSEP_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .VSYNC_IN_CH0(VSYNC_IN_CH0),
  .VSYNC_IN_CH1(VSYNC_IN_CH1), .GREEN_SYNC_IN_CH0(GREEN_SYNC_IN_CH0),
  .GREEN_SYNC_IN_CH1(GREEN_SYNC_IN_CH1), .EXTERNAL_PIXEL_CLOCK(EXTERNAL_PIXEL_CLOCK),
  .SLICED_SYNC_OUT(SLICED_SYNC_OUT), .VSYNC_OUT(VSYNC_OUT), .PIXEL_CLOCK_OUT(PIXEL_CLOCK_OUT));
`default_nettype wire

// ### scc_video_src.sv
/*
  behavioural video source: hsync, vsync and green levels, two channels.
  driven by task calls from the bench; levels change just after clk rises.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_video_src (
  // clock
  input wire logic clk,
  // sync levels
  output logic hs0,
  output logic hs1,
  output logic vs0,
  output logic vs1,
  // green levels in mV
  output logic [9:0] g0,
  output logic [9:0] g1
);
  initial {hs0, hs1, vs0, vs1, g0, g1} = {4'hc, 10'h200, 10'h200};
  task automatic hs(input logic ch, input logic lvl);
    @(posedge clk);
    hs0 <= ch ? hs0 : lvl;
    hs1 <= ch ? lvl : hs1;
  endtask
  task automatic vsync(input logic v0, input logic v1);
    @(posedge clk);
    vs0 <= v0;
    vs1 <= v1;
  endtask
  task automatic green(input logic [9:0] v0, input logic [9:0] v1);
    @(posedge clk);
    g0 <= v0;
    g1 <= v1;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
/*
  self-checking bench for scc_top: wishbone tasks, one task per scenario.
  assumes scc_video_src on the sync pins; vertical separation shortened.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int VSEP = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic coast = 1'b0;
  logic ext = 1'b0;
  logic ack, sliced, hs_out, vs_out, pix, hs0, hs1, vs0, vs1;
  logic [9:0] g0, g1;
  int bad_count = 0, checks_done = 0, cycles = 0;
  initial forever #25 clk = ~clk;
  scc_top #(.VSEP_CYCLES(VSEP)) dut (
    .CORE_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .HSYNC_IN_CH0(hs0), .HSYNC_IN_CH1(hs1), .VSYNC_IN_CH0(vs0), .VSYNC_IN_CH1(vs1),
    .GREEN_SYNC_IN_CH0(g0), .GREEN_SYNC_IN_CH1(g1), .COAST_IN(coast),
    .EXTERNAL_PIXEL_CLOCK(ext), .SLICED_SYNC_OUT(sliced), .HSYNC_REBUILT_OUT(hs_out),
    .VSYNC_OUT(vs_out), .PIXEL_CLOCK_OUT(pix));
  scc_video_src src (
    .clk(clk), .hs0(hs0), .hs1(hs1), .vs0(vs0), .vs1(vs1), .g0(g0), .g1(g1));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // cycles of rebuilt pulse seen within a short wait
  task automatic pulse_len(output logic [31:0] w);
    w = 32'h0;
    for (int i = 0; i < 12 && hs_out !== 1'b1; i++) @(posedge clk);
    while (hs_out === 1'b1 && w < 32'h100) begin
      w++;
      @(posedge clk);
    end
  endtask
  task automatic t_regs;
    rd_chk("hsync cfg", 8'h48, 32'h0);
    rd_chk("coast cfg", 8'h60, 32'h20);
    rd_chk("threshold", 8'h80, 32'h0f);
    wb(1'b1, 8'h48, 32'h30);
    rd_chk("hsync cfg rw", 8'h48, 32'h30);
    wb(1'b1, 8'h80, 32'h0);
    rd_chk("threshold floor", 8'h80, 32'h01);
    wb(1'b1, 8'h80, 32'h3f);
    rd_chk("threshold ceiling", 8'h80, 32'h21);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    rd_chk("unmapped", 8'hfc, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_slice;
    logic [5:0] steps [3] = '{6'h1, 6'hf, 6'h21};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h80, {26'h0, steps[i]});
      src.green(10'h0, 10'h3ff);
      tick(3);
      src.green(steps[i] * 10'ha - 10'h2, 10'h3ff);
      tick(2);
      chk("slice below", {31'h0, sliced}, 32'h0);
      src.green(10'h0, 10'h3ff);
      tick(3);
      src.green(steps[i] * 10'ha + 10'h2, 10'h3ff);
      tick(2);
      chk("slice above", {31'h0, sliced}, 32'h1);
    end
    $display("test slice done");
  endtask
  task automatic t_vsync;
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, 8'h84, 32'(c));
      src.vsync(c == 0, c == 1);
      tick(3);
      chk("vsync select", {31'h0, vs_out}, 32'h1);
      src.vsync(c == 1, c == 0);
      tick(3);
      chk("vsync other", {31'h0, vs_out}, 32'h0);
    end
    wb(1'b1, 8'h84, 32'h2);
    src.green(10'h0, 10'h0);
    tick(VSEP + 8);
    chk("vertical flag", {31'h0, vs_out}, 32'h1);
    src.green(10'h200, 10'h200);
    tick(VSEP + 8);
    chk("vertical flag end", {31'h0, vs_out}, 32'h0);
    $display("test vsync done");
  endtask
  task automatic t_hsync;
    logic [31:0] w;
    wb(1'b1, 8'h8c, 32'hfff);
    wb(1'b1, 8'h88, 32'h4);
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, 8'h48, 32'(p) << 4);
      wb(1'b1, 8'h84, 32'h9);
      src.hs(1'b0, p == 0);
      src.hs(1'b1, p == 0);
      tick(40);
      src.hs(1'b1, p == 1);
      pulse_len(w);
      chk("leading edge pulse", w, 32'h4);
      tick(10);
      src.hs(1'b1, p == 0);
      pulse_len(w);
      chk("trailing edge", w, 32'h0);
      src.hs(1'b0, p == 1);
      pulse_len(w);
      chk("other channel", w, 32'h0);
    end
    $display("test hsync done");
  endtask
  task automatic t_coast;
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, 8'h60, 32'(p) << 5);
      for (int l = 0; l < 2; l++) begin
        coast <= 1'(l);
        wb(1'b0, 8'h90, 32'h0);
        chk("coast status", {30'h0, rd[1:0]}, 32'(l == p));
      end
    end
    // coast active: a leading edge leaves the divider alone
    wb(1'b1, 8'h8c, 32'h1);
    src.hs(1'b1, 1'b1);
    tick(4);
    wb(1'b0, 8'h90, 32'h0);
    chk("divider in coast", {16'h0, rd[31:16]}, 32'h1);
    coast <= 1'b0;
    wb(1'b1, 8'h60, 32'h20);
    // coast released: next leading edge steps the divider once
    src.hs(1'b1, 1'b0);
    src.hs(1'b1, 1'b1);
    tick(4);
    wb(1'b0, 8'h90, 32'h0);
    chk("divider tracks line", {16'h0, rd[31:16]}, 32'h2);
    $display("test coast done");
  endtask
  task automatic t_ext;
    logic [31:0] n;
    wb(1'b1, 8'h84, 32'h4);
    wb(1'b0, 8'h90, 32'h0);
    chk("ext selected", {30'h0, rd[1:0]}, 32'h2);
    for (int c = 0; c < 2; c++) begin
      coast <= 1'(c);
      tick(4);
      n = 32'h0;
      for (int i = 0; i < 66; i++) begin
        ext <= i < 60 && i % 6 >= 3;
        @(posedge clk);
        n += {31'h0, pix};
      end
      chk("ext pulses", n, 32'ha);
    end
    coast <= 1'b0;
    $display("test ext done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_slice;
    t_vsync;
    t_hsync;
    t_coast;
    t_ext;
    report_and_stop;
  end
endmodule
`default_nettype wire
